// ==== shared/wdc_pkg.sv ====
package wdc_pkg;
   // ==========================================================
   // register bus
   localparam int ADDR_W = 2;
   localparam int DATA_W = 8;
   localparam logic [1:0] OFF_CTRL_STATUS = 2'h0;
   localparam logic [1:0] OFF_COUNTER = 2'h1;
   localparam logic [1:0] OFF_IRQ_STATUS = 2'h2;
   localparam logic [1:0] OFF_IRQ_MASK = 2'h3;
   // ==========================================================
   // control/status field positions
   localparam int BIT_FLAG = 7;
   localparam int BIT_MODE = 6;
   localparam int BIT_EN = 5;
   localparam int BIT_SRC_SEL = 4;
   localparam int BIT_RST_SEL = 3;
   localparam int CLK_SEL_LSB = 0;
   // ==========================================================
   // reset values and counter constants
   localparam logic [7:0] CNT_RESET = 8'h00;
   localparam logic [7:0] CNT_MAX = 8'hFF;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   // ==========================================================
   // interrupt status bits
   localparam int IRQ_W = 3;
   localparam int EV_WRAP = 0;
   localparam int EV_NMI = 1;
   localparam int EV_RST = 2;
   localparam logic [2:0] IRQ_RESET = 3'h0;
   // ==========================================================
   // prescaler
   localparam int PRESC_WIDTH = 16;
   // ==========================================================
   // software-owned control fields
   typedef struct packed {
      logic mode;
      logic en;
      logic src_sel;
      logic rst_sel;
      logic [2:0] clk_sel;
   } wdc_ctrl_t;
   localparam wdc_ctrl_t CTRL_RESET = '{mode: 1'b0, en: 1'b0, src_sel: 1'b0, rst_sel: 1'b0,
                                        clk_sel: 3'h0};
   // clock select to prescaler tap: divide by 2^(2*sel+1)
   function automatic logic [3:0] tap_index(input logic [2:0] sel);
      return {sel, 1'b0};
   endfunction
endpackage

// ==== rtl/wdc_prescaler.sv ====
`timescale 1ns/1ps
`default_nettype none
module wdc_prescaler #(
   parameter int WIDTH = wdc_pkg::PRESC_WIDTH
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // control
   input wire logic step_i,
   input wire logic [2:0] sel_i,
   // selected tap rising edge
   output logic tick_o
);
   logic [WIDTH-1:0] div_reg;
   logic [WIDTH-1:0] div_next;
   logic tap_prev_reg;
   logic tap;

   // ==========================================================
   // divider chain, advanced on each step
   assign div_next = div_reg + {{(WIDTH-1){1'b0}}, step_i};
   assign tap = div_reg[wdc_pkg::tap_index(sel_i)];

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_next;
      end
   end

   // one-cycle tick on rising edge of the tap
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tap_prev_reg <= 1'b0;
         tick_o <= 1'b0;
      end else begin
         tap_prev_reg <= tap;
         tick_o <= tap & ~tap_prev_reg;
      end
   end
endmodule
`default_nettype wire

// ==== rtl/wdc_irq.sv ====
`timescale 1ns/1ps
`default_nettype none
module wdc_irq #(
   parameter int N = wdc_pkg::IRQ_W
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // events, one-cycle pulses
   input wire logic [N-1:0] event_i,
   // register writes
   input wire logic status_wr_i,
   input wire logic mask_wr_i,
   input wire logic [N-1:0] wdata_i,
   // state
   output logic [N-1:0] status_o,
   output logic [N-1:0] mask_o,
   output logic irq_o
);
   logic [N-1:0] status_next;

   // ==========================================================
   // sticky status, write one clears, set wins
   always_comb begin
      status_next = status_o;
      if (status_wr_i) begin
         status_next = status_next & ~wdata_i;
      end
      status_next = status_next | event_i;
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         status_o <= wdc_pkg::IRQ_RESET;
      end else begin
         status_o <= status_next;
      end
   end

   // mask register
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mask_o <= wdc_pkg::IRQ_RESET;
      end else if (mask_wr_i) begin
         mask_o <= wdata_i;
      end
   end

   // level interrupt
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(status_next & mask_o);
      end
   end
endmodule
`default_nettype wire

// ==== rtl/wdc_top.sv ====
// Functional notes
// - overflow flag bit 7 sets when counter wraps FF to 00
// - flag clears by read with flag 1 then write 0; write 1 ignored
// - internal reset request on overflow clears the flag by itself
// - bit 6 picks interval (0) or watchdog (1) mode, reset 0
// - bit 5 set starts counting; cleared stops and zeroes counter
// - bit 4 picks main (0) or sub (1) prescaler as count source
// - watchdog mode: bit 3 zero asks NMI, one asks internal reset
// - counter is eight-bit up-counter, software read/write, reset zero
// - interval mode: each overflow raises interval timer interrupt
`timescale 1ns/1ps
`default_nettype none
module wdc_top (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // sub-clock, synchronous level
   input wire logic sub_clk_i,
   // register port
   input wire logic [wdc_pkg::ADDR_W-1:0] addr_i,
   input wire logic [wdc_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [wdc_pkg::DATA_W-1:0] rdata_o,
   // overflow actions
   output logic interval_overflow_interrupt_o,
   output logic nmi_req_o,
   output logic int_reset_req_o,
   // interrupt
   output logic irq_o
);
   // ==========================================================
   // reset release
   logic rst_meta_reg;
   logic rst_sync_reg;
   logic rst_n;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   assign rst_n = rst_sync_reg;

   // ==========================================================
   // declarations
   wdc_pkg::wdc_ctrl_t ctrl_reg;
   logic overflow_flag_reg;
   logic overflow_flag_next;
   logic clear_armed_reg;
   logic [7:0] watchdog_counter_reg;
   logic [7:0] watchdog_counter_next;
   logic sub_prev_reg;
   logic sub_step;
   logic main_tick;
   logic sub_tick;
   logic count_tick;
   logic wrap_evt;
   logic ctrl_wr;
   logic ctrl_rd;
   logic cnt_wr;
   logic irq_st_wr;
   logic irq_mask_wr;
   logic [wdc_pkg::IRQ_W-1:0] irq_events;
   logic [wdc_pkg::IRQ_W-1:0] irq_status;
   logic [wdc_pkg::IRQ_W-1:0] irq_mask;
   logic [7:0] ctrl_rdata;
   logic [7:0] rdata_next;

   // ==========================================================
   // address decode
   assign ctrl_wr = wr_i && (addr_i == wdc_pkg::OFF_CTRL_STATUS);
   assign ctrl_rd = rd_i && (addr_i == wdc_pkg::OFF_CTRL_STATUS);
   assign cnt_wr = wr_i && (addr_i == wdc_pkg::OFF_COUNTER);
   assign irq_st_wr = wr_i && (addr_i == wdc_pkg::OFF_IRQ_STATUS);
   assign irq_mask_wr = wr_i && (addr_i == wdc_pkg::OFF_IRQ_MASK);

   // ==========================================================
   // count sources
   // sub-clock edge steps its own prescaler
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         sub_prev_reg <= 1'b0;
      end else begin
         sub_prev_reg <= sub_clk_i;
      end
   end
   assign sub_step = sub_clk_i & ~sub_prev_reg;

   wdc_prescaler #(
      .WIDTH(wdc_pkg::PRESC_WIDTH)
   ) u_main_clock_prescaler (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n),
      .step_i(1'b1),
      .sel_i(ctrl_reg.clk_sel),
      .tick_o(main_tick)
   );

   wdc_prescaler #(
      .WIDTH(wdc_pkg::PRESC_WIDTH)
   ) u_sub_clock_prescaler (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n),
      .step_i(sub_step),
      .sel_i(ctrl_reg.clk_sel),
      .tick_o(sub_tick)
   );

   // source select
   assign count_tick = ctrl_reg.src_sel ? sub_tick : main_tick;

   // ==========================================================
   // watchdog counter
   // wrap from all ones, a software write takes precedence
   assign wrap_evt = ctrl_reg.en && count_tick && !cnt_wr &&
                     (watchdog_counter_reg == wdc_pkg::CNT_MAX);

   always_comb begin
      watchdog_counter_next = watchdog_counter_reg;
      if (!ctrl_reg.en) begin
         watchdog_counter_next = wdc_pkg::CNT_RESET;
      end else if (cnt_wr) begin
         watchdog_counter_next = wdata_i;
      end else if (count_tick) begin
         watchdog_counter_next = watchdog_counter_reg + 8'h01;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         watchdog_counter_reg <= wdc_pkg::CNT_RESET;
      end else begin
         watchdog_counter_reg <= watchdog_counter_next;
      end
   end

   // ==========================================================
   // control fields
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= wdc_pkg::CTRL_RESET;
      end else if (ctrl_wr) begin
         ctrl_reg.mode <= wdata_i[wdc_pkg::BIT_MODE];
         ctrl_reg.en <= wdata_i[wdc_pkg::BIT_EN];
         ctrl_reg.src_sel <= wdata_i[wdc_pkg::BIT_SRC_SEL];
         ctrl_reg.rst_sel <= wdata_i[wdc_pkg::BIT_RST_SEL];
         ctrl_reg.clk_sel <= wdata_i[wdc_pkg::CLK_SEL_LSB +: 3];
      end
   end

   // ==========================================================
   // overflow flag
   // arm on a read that sees the flag set
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         clear_armed_reg <= 1'b0;
      end else if (!overflow_flag_next) begin
         clear_armed_reg <= 1'b0;
      end else if (ctrl_rd && overflow_flag_reg) begin
         clear_armed_reg <= 1'b1;
      end
   end

   // clears by armed write of zero or by internal reset; set wins
   always_comb begin
      overflow_flag_next = overflow_flag_reg;
      if (ctrl_wr && !wdata_i[wdc_pkg::BIT_FLAG] && clear_armed_reg) begin
         overflow_flag_next = 1'b0;
      end
      if (int_reset_req_o) begin
         overflow_flag_next = 1'b0;
      end
      if (wrap_evt) begin
         overflow_flag_next = 1'b1;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         overflow_flag_reg <= 1'b0;
      end else begin
         overflow_flag_reg <= overflow_flag_next;
      end
   end

   // ==========================================================
   // overflow actions
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         nmi_req_o <= 1'b0;
         int_reset_req_o <= 1'b0;
      end else begin
         nmi_req_o <= wrap_evt && ctrl_reg.mode && !ctrl_reg.rst_sel;
         int_reset_req_o <= wrap_evt && ctrl_reg.mode && ctrl_reg.rst_sel;
      end
   end

   // interval request follows the flag in interval mode
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         interval_overflow_interrupt_o <= 1'b0;
      end else begin
         interval_overflow_interrupt_o <= overflow_flag_reg && !ctrl_reg.mode;
      end
   end

   // ==========================================================
   // interrupt status and mask
   assign irq_events[wdc_pkg::EV_WRAP] = wrap_evt;
   assign irq_events[wdc_pkg::EV_NMI] = wrap_evt && ctrl_reg.mode && !ctrl_reg.rst_sel;
   assign irq_events[wdc_pkg::EV_RST] = wrap_evt && ctrl_reg.mode && ctrl_reg.rst_sel;

   wdc_irq #(
      .N(wdc_pkg::IRQ_W)
   ) u_irq (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n),
      .event_i(irq_events),
      .status_wr_i(irq_st_wr),
      .mask_wr_i(irq_mask_wr),
      .wdata_i(wdata_i[wdc_pkg::IRQ_W-1:0]),
      .status_o(irq_status),
      .mask_o(irq_mask),
      .irq_o(irq_o)
   );

   // ==========================================================
   // read path, data in the cycle after the strobe only
   assign ctrl_rdata = {overflow_flag_reg, ctrl_reg.mode, ctrl_reg.en, ctrl_reg.src_sel,
                        ctrl_reg.rst_sel, ctrl_reg.clk_sel};

   always_comb begin
      rdata_next = wdc_pkg::ZERO_BYTE;
      if (rd_i) begin
         case (addr_i)
            wdc_pkg::OFF_CTRL_STATUS: begin
               rdata_next = ctrl_rdata;
            end
            wdc_pkg::OFF_COUNTER: begin
               rdata_next = watchdog_counter_reg;
            end
            wdc_pkg::OFF_IRQ_STATUS: begin
               rdata_next = {5'h00, irq_status};
            end
            wdc_pkg::OFF_IRQ_MASK: begin
               rdata_next = {5'h00, irq_mask};
            end
            default: begin
               rdata_next = wdc_pkg::ZERO_BYTE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         rdata_o <= wdc_pkg::ZERO_BYTE;
      end else begin
         rdata_o <= rdata_next;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n);

   sequence s_armed_read;
      ctrl_rd && overflow_flag_reg;
   endsequence

   sequence s_zero_write;
      ctrl_wr && !wdata_i[wdc_pkg::BIT_FLAG] && !wrap_evt;
   endsequence

   chk_flag_set_wrap: assert property (
      wrap_evt |=> overflow_flag_reg && (watchdog_counter_reg == wdc_pkg::CNT_RESET))
      else $error("overflow flag not set on wrap");

   chk_flag_write_one: assert property (
      overflow_flag_reg && ctrl_wr && wdata_i[wdc_pkg::BIT_FLAG] && !int_reset_req_o
      |=> overflow_flag_reg)
      else $error("writing one changed the overflow flag");

   chk_flag_clear_seq: assert property (
      s_armed_read ##1 (s_zero_write and !int_reset_req_o) |=> !overflow_flag_reg)
      else $error("armed zero write did not clear the flag");

   chk_flag_unarmed_keep: assert property (
      overflow_flag_reg && !clear_armed_reg && !int_reset_req_o && ctrl_wr
      |=> overflow_flag_reg)
      else $error("flag cleared without a prior read");

   chk_reset_clears_flag: assert property (
      int_reset_req_o && !wrap_evt |=> !overflow_flag_reg)
      else $error("internal reset left the overflow flag set");

   chk_mode_write: assert property (
      ctrl_wr |=> ctrl_reg.mode == $past(wdata_i[wdc_pkg::BIT_MODE]))
      else $error("mode bit did not take written value");

   chk_disable_zero: assert property (
      !ctrl_reg.en |=> watchdog_counter_reg == wdc_pkg::CNT_RESET)
      else $error("disabled counter not held at zero");

   chk_sub_source: assert property (
      ctrl_reg.en && ctrl_reg.src_sel && !sub_tick && !cnt_wr |=> $stable(watchdog_counter_reg))
      else $error("counter moved without a sub-clock tick");

   chk_nmi_action: assert property (
      wrap_evt && ctrl_reg.mode && !ctrl_reg.rst_sel |=> nmi_req_o && !int_reset_req_o)
      else $error("nmi action not taken");

   chk_reset_action: assert property (
      wrap_evt && ctrl_reg.mode && ctrl_reg.rst_sel
      |=> int_reset_req_o && !nmi_req_o ##1 !overflow_flag_reg)
      else $error("internal reset action not taken");

   chk_counter_write: assert property (
      ctrl_reg.en && cnt_wr |=> watchdog_counter_reg == $past(wdata_i))
      else $error("counter write lost");

   chk_interval_irq: assert property (
      wrap_evt && !ctrl_reg.mode && !ctrl_wr |=> ##1 interval_overflow_interrupt_o)
      else $error("interval overflow interrupt missing");

   chk_count_step: assert property (
      ctrl_reg.en && count_tick && !cnt_wr
      |=> watchdog_counter_reg == $past(watchdog_counter_reg) + 8'h01)
      else $error("counter did not step on tick");

   chk_count_hold: assert property (
      ctrl_reg.en && !count_tick && !cnt_wr |=> $stable(watchdog_counter_reg))
      else $error("counter moved without a tick");
endmodule
`default_nettype wire

// ==== tb/test_wdc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// self-checking bench for the watchdog channel block
`define CHK(a, b, m) begin n_tests++; if ((a) !== (b)) begin fails++; \
   $display("MISMATCH t=%0t %s", $time, m); end end
module test_wdc_top;
   // ==========================================================
   // clock, reset and ports
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic sub_clk_i = 1'b0;
   logic [wdc_pkg::ADDR_W-1:0] addr_i = 2'h0;
   logic [wdc_pkg::DATA_W-1:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [wdc_pkg::DATA_W-1:0] rdata_o;
   logic interval_overflow_interrupt_o;
   logic nmi_req_o;
   logic int_reset_req_o;
   logic irq_o;
   int fails = 0;
   int n_tests = 0;
   int n_nmi = 0;
   int n_rst = 0;
   logic [7:0] rv;

   // 50 MHz system clock
   always #10 mclk_i = ~mclk_i;

   wdc_top wdc_top_inst (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .sub_clk_i(sub_clk_i),
      .addr_i(addr_i),
      .wdata_i(wdata_i),
      .wr_i(wr_i),
      .rd_i(rd_i),
      .rdata_o(rdata_o),
      .interval_overflow_interrupt_o(interval_overflow_interrupt_o),
      .nmi_req_o(nmi_req_o),
      .int_reset_req_o(int_reset_req_o),
      .irq_o(irq_o)
   );

   // count one-cycle overflow action pulses
   always @(posedge mclk_i) begin
      if (nmi_req_o === 1'b1) n_nmi++;
      if (int_reset_req_o === 1'b1) n_rst++;
   end

   // ==========================================================
   // bus and stimulus tasks
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge mclk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask

   task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp, input string m);
      logic [7:0] d;
      rd(a, d);
      `CHK(d, exp, m)
   endtask

   // n sub-clock rising edges, then let the tick land
   task automatic sub_pulses(input int n);
      repeat (n) begin
         @(posedge mclk_i) sub_clk_i <= 1'b1;
         repeat (2) @(posedge mclk_i);
         sub_clk_i <= 1'b0;
         repeat (2) @(posedge mclk_i);
      end
      repeat (4) @(posedge mclk_i);
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset;
      rd_chk(2'h0, 8'h00, "ctrl reset");
      rd_chk(2'h1, 8'h00, "counter reset");
      rd_chk(2'h2, 8'h00, "irq status reset");
      rd_chk(2'h3, 8'h00, "irq mask reset");
      `CHK(irq_o, 1'b0, "irq after reset")
      $display("test reset done");
   endtask

   task automatic t_count;
      wr(2'h0, 8'h30);
      sub_pulses(20);
      rd_chk(2'h1, 8'h0A, "count per sub tick");
      wr(2'h1, 8'h5A);
      rd_chk(2'h1, 8'h5A, "counter write");
      wr(2'h0, 8'h10);
      rd_chk(2'h1, 8'h00, "disable zeroes");
      wr(2'h1, 8'h33);
      sub_pulses(4);
      rd_chk(2'h1, 8'h00, "held while disabled");
      wr(2'h0, 8'h20);
      repeat (40) @(posedge mclk_i);
      rd(2'h1, rv);
      `CHK(rv != 8'h00, 1'b1, "main prescaler counts")
      wr(2'h0, 8'h10);
      $display("test count done");
   endtask

   task automatic t_interval;
      wr(2'h3, 8'h01);
      wr(2'h0, 8'h30);
      wr(2'h1, 8'hFF);
      sub_pulses(2);
      `CHK(interval_overflow_interrupt_o, 1'b1, "interval irq")
      `CHK(irq_o, 1'b1, "masked-in irq")
      wr(2'h0, 8'h30);
      wr(2'h0, 8'hB0);
      rd_chk(2'h0, 8'hB0, "flag kept without read");
      rd_chk(2'h1, 8'h00, "wrapped to zero");
      wr(2'h0, 8'h30);
      rd_chk(2'h0, 8'h30, "flag cleared");
      @(posedge mclk_i);
      #1 `CHK(interval_overflow_interrupt_o, 1'b0, "interval irq drops")
      rd_chk(2'h2, 8'h01, "status overflow bit");
      wr(2'h2, 8'h01);
      rd_chk(2'h2, 8'h00, "status w1c");
      `CHK(irq_o, 1'b0, "irq cleared")
      $display("test interval done");
   endtask

   task automatic t_nmi;
      int b_nmi;
      int b_rst;
      wr(2'h0, 8'h70);
      wr(2'h1, 8'hFF);
      b_nmi = n_nmi;
      b_rst = n_rst;
      sub_pulses(2);
      `CHK(n_nmi, b_nmi + 1, "one nmi pulse")
      `CHK(n_rst, b_rst, "no reset pulse")
      `CHK(interval_overflow_interrupt_o, 1'b0, "no interval irq")
      rd_chk(2'h0, 8'hF0, "flag in watchdog mode");
      wr(2'h0, 8'h70);
      rd_chk(2'h0, 8'h70, "flag cleared");
      $display("test nmi done");
   endtask

   task automatic t_wdrst;
      int b_nmi;
      int b_rst;
      wr(2'h0, 8'h78);
      wr(2'h1, 8'hFF);
      b_nmi = n_nmi;
      b_rst = n_rst;
      sub_pulses(2);
      `CHK(n_rst, b_rst + 1, "one reset pulse")
      `CHK(n_nmi, b_nmi, "no nmi pulse")
      rd_chk(2'h0, 8'h78, "flag auto cleared");
      rd_chk(2'h2, 8'h07, "status all events");
      `CHK(irq_o, 1'b1, "irq pending")
      wr(2'h2, 8'h07);
      rd_chk(2'h2, 8'h00, "status cleared");
      `CHK(irq_o, 1'b0, "irq low")
      $display("test watchdog reset done");
   endtask

   // nonzero clock select on the sub source: tap 2 rises every 8 sub edges
   task automatic t_clksel;
      // disabled while the tap moves, so a switch-over tick cannot count
      wr(2'h0, 8'h11);
      repeat (2) @(posedge mclk_i);
      wr(2'h0, 8'h31);
      // 30 sub edges so far: 16 more cross 36 and 44, two ticks
      sub_pulses(16);
      rd_chk(2'h1, 8'h02, "clock select divides sub edges");
      wr(2'h0, 8'h10);
      rd_chk(2'h1, 8'h00, "disable zeroes again");
      $display("test clock select done");
   endtask

   // ==========================================================
   // verdict and run control
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // watchdog for a hung run
   initial begin
      #200000;
      fails++;
      summarize();
   end

   initial begin
      repeat (6) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      t_reset();
      t_count();
      t_interval();
      t_nmi();
      t_wdrst();
      t_clksel();
      summarize();
   end
endmodule
`default_nettype wire
